// ==== cmh_status.sv ====
// message handler status, interrupt identifier and transmit request logic
//
// Summary of operation
// - receive with rx_irq_enable set marks the object's pending flag; else untouched.
// - transmit done with tx_irq_enable set marks the pending flag; else untouched.
// - a pending object is an interrupt source reported unless outranked.
// - remote frame with remote_answer_enable set raises transmit_request; else untouched.
// - transmit_request 1 means waiting to send, 0 means not waiting.
// - length codes 0..8 mean that many bytes, 9..15 mean eight.
// - a stored data frame overwrites the object's length code.
// - data byte 0 is the first received byte, byte 7 the last.
// - a stored data frame writes all eight bytes of the object.
// - status words, identifier and transmit summaries ignore bus writes.
// - identifier shows the highest priority pending source, not the oldest.
// - a pending source stays until software clears it.
// - irq rises when identifier is nonzero and module_irq_enable is set.
// - irq holds until identifier is zero or module_irq_enable drops.
// - the status interrupt outranks every object interrupt.
// - lower object number wins: object 1 highest, object 32 lowest.
// - clearing an object's pending flag removes it from identifier selection.
// - reading the status register clears the status interrupt.
// - identifier 0 none, 1..32 object number, 0x8000 status interrupt.
// - transmit_request set or cleared by software, remote frames, finished transmissions.
// - two words gather transmit_request: objects 1..16 low, 17..32 high.
// - transmit object answers a matching remote frame only with remote_answer_enable.
`timescale 1ns/1ps
`default_nettype none
`include "cmh_map.svh"

module cmh_status
	import cmh_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [`CMH_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire cmh_core_evt_s coreEvt,
	input wire logic statusEvent,
	output logic [31:0] txRequestOut,
	output logic irq
);

	// -------------------------------------------------
	// state
	// -------------------------------------------------
	// per-object enables written by software
	logic [31:0] rxIrqEnable;
	logic [31:0] txIrqEnable;
	logic [31:0] remoteAnswerEnable;

	// sticky per-object flags
	logic [31:0] irqPending;
	logic [31:0] transmitRequest;

	// module enable, status interrupt and its companions
	logic moduleIrqEnable;
	logic statusIrq;
	logic rxOkSeen;
	logic txOkSeen;
	logic [15:0] irqIdentifier;

	// bus handshake and object readback
	logic [4:0] objSelect;
	logic ackDone;
	logic [31:0] readWord;
	cmh_obj_s readObj;

	// -------------------------------------------------
	// bus handshake
	// -------------------------------------------------
	// every access takes one wait cycle so read data can come from a flop
	wire busReq = avs_read | avs_write;
	wire busAccept = busReq & ackDone;
	wire wrAccept = avs_write & busAccept;
	wire rdAccept = avs_read & busAccept;
	assign avs_waitrequest = busReq & ~ackDone;

	// ackDone marks the answer cycle; a request still held after it gets a fresh wait cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			ackDone <= 1'b0;
		end else begin
			ackDone <= busReq & ~ackDone;
		end
	end

	// -------------------------------------------------
	// address decode
	// -------------------------------------------------
	// one select per mapped word
	// unmapped addresses select nothing and read as zero
	wire selCtrl = avs_address == `CMH_CTRL_OFS;
	wire selStat = avs_address == `CMH_STAT_OFS;
	wire selId = avs_address == `CMH_IRQ_SOURCE_ID_OFS;
	wire selTxLow = avs_address == `CMH_TX_PENDING_LOW_OFS;
	wire selTxHigh = avs_address == `CMH_TX_PENDING_HIGH_OFS;
	wire selPend = avs_address == `CMH_IRQ_PENDING_OFS;
	wire selRxIe = avs_address == `CMH_RX_IE_OFS;
	wire selTxIe = avs_address == `CMH_TX_IE_OFS;
	wire selRmt = avs_address == `CMH_RMT_EN_OFS;
	wire selCmd = avs_address == `CMH_CMD_OFS;
	wire selObj = avs_address == `CMH_OBJ_SEL_OFS;
	wire selDataLow = avs_address == `CMH_DATA_LOW_OFS;
	wire selDataHigh = avs_address == `CMH_DATA_HIGH_OFS;
	wire selDlc = avs_address == `CMH_DLC_OFS;

	// byte-lane mask for writable words
	wire [31:0] laneMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// lanes with their enable low keep the old bits
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	// -------------------------------------------------
	// core events, decoded per object
	// -------------------------------------------------
	// one-hot of the object named by the core, qualified below by event kind
	wire [31:0] evtOneHot = 32'h00000001 << coreEvt.objIndex;
	wire evtRxData = coreEvt.valid & (coreEvt.kind == CMH_EVT_RX_DATA);
	wire evtRxRemote = coreEvt.valid & (coreEvt.kind == CMH_EVT_RX_REMOTE);
	wire evtTxDone = coreEvt.valid & (coreEvt.kind == CMH_EVT_TX_DONE);

	// hardware sets and clears; one object per event, so they never collide
	wire [31:0] hwPendSetRx = evtRxData ? (evtOneHot & rxIrqEnable) : 32'h00000000;
	wire [31:0] hwPendSetTx = evtTxDone ? (evtOneHot & txIrqEnable) : 32'h00000000;
	wire [31:0] hwTxReqSet = evtRxRemote ? (evtOneHot & remoteAnswerEnable) : 32'h00000000;
	wire [31:0] hwTxReqClr = evtTxDone ? evtOneHot : 32'h00000000;

	// -------------------------------------------------
	// software command decode
	// -------------------------------------------------
	// opcode and object share the low half, so both low lanes must be enabled
	wire cmdWrite = wrAccept & selCmd & avs_byteenable[0] & avs_byteenable[1];
	wire [2:0] cmdCode = avs_writedata[10:8];
	wire [4:0] cmdObj = avs_writedata[4:0];
	wire [31:0] cmdOneHot = 32'h00000001 << cmdObj;
	// each opcode becomes a one-hot mask on the named object
	wire [31:0] swTxReqSet = (cmdWrite && cmdCode == CMH_CMD_SET_TXREQ) ? cmdOneHot : 32'h00000000;
	wire [31:0] swTxReqClr = (cmdWrite && cmdCode == CMH_CMD_CLR_TXREQ) ? cmdOneHot : 32'h00000000;
	wire [31:0] swPendSet = (cmdWrite && cmdCode == CMH_CMD_SET_PEND) ? cmdOneHot : 32'h00000000;
	wire [31:0] swPendClr = (cmdWrite && cmdCode == CMH_CMD_CLR_PEND) ? cmdOneHot : 32'h00000000;

	// hardware sets win over any clear landing in the same cycle
	wire [31:0] next_irqPending = (irqPending & ~swPendClr)
		| swPendSet | hwPendSetRx | hwPendSetTx;
	wire [31:0] next_transmitRequest = (transmitRequest & ~(swTxReqClr | hwTxReqClr))
		| swTxReqSet | hwTxReqSet;

	// -------------------------------------------------
	// per-object flag registers
	// -------------------------------------------------
	// sticky: only a software command or a core event moves a bit
	always_ff @(posedge clk) begin
		if (reset) begin
			irqPending <= `CMH_RESET_WORD;
			transmitRequest <= `CMH_RESET_WORD;
		end else begin
			irqPending <= next_irqPending;
			transmitRequest <= next_transmitRequest;
		end
	end

	// -------------------------------------------------
	// software configuration registers
	// -------------------------------------------------
	// enables honour byte lanes so one group of eight objects can change alone
	always_ff @(posedge clk) begin
		if (reset) begin
			rxIrqEnable <= `CMH_RESET_WORD;
			txIrqEnable <= `CMH_RESET_WORD;
			remoteAnswerEnable <= `CMH_RESET_WORD;
			moduleIrqEnable <= 1'b0;
			objSelect <= 5'h00;
		end else if (wrAccept) begin
			if (selRxIe) begin
				rxIrqEnable <= merge(rxIrqEnable, avs_writedata, laneMask);
			end
			if (selTxIe) begin
				txIrqEnable <= merge(txIrqEnable, avs_writedata, laneMask);
			end
			if (selRmt) begin
				remoteAnswerEnable <= merge(remoteAnswerEnable, avs_writedata, laneMask);
			end
			if (selCtrl && avs_byteenable[0]) begin
				moduleIrqEnable <= avs_writedata[`CMH_CTRL_IE_BIT];
			end
			if (selObj && avs_byteenable[0]) begin
				objSelect <= avs_writedata[4:0];
			end
		end
	end

	// -------------------------------------------------
	// status interrupt and status bits
	// -------------------------------------------------
	// a status event in the same cycle as the clearing read survives it
	wire statusRead = rdAccept & selStat;
	// rx and tx ok bits share the clearing read with the status interrupt
	always_ff @(posedge clk) begin
		if (reset) begin
			statusIrq <= 1'b0;
			rxOkSeen <= 1'b0;
			txOkSeen <= 1'b0;
		end else begin
			statusIrq <= statusEvent | (statusIrq & ~statusRead);
			rxOkSeen <= evtRxData | evtRxRemote | (rxOkSeen & ~statusRead);
			txOkSeen <= evtTxDone | (txOkSeen & ~statusRead);
		end
	end

	// -------------------------------------------------
	// identifier priority encoder
	// -------------------------------------------------
	// scan from object 32 down so the lowest number is the last to win
	function automatic logic [15:0] pickSource(input logic stat, input logic [31:0] pend);
		logic [15:0] id;
		id = `CMH_ID_NONE;
		for (int i = 31; i >= 0; i--) begin
			if (pend[i]) begin
				id = 16'(i + 1);
			end
		end
		if (stat) begin
			id = `CMH_ID_STATUS;
		end
		pickSource = id;
	endfunction

	// identifier follows the present flags only, so arrival order is irrelevant
	// enables only gate the setting: a flag stays a source after its enable drops
	wire [15:0] next_irqIdentifier = pickSource(statusIrq, irqPending);

	// irq comes from the registered identifier: one cycle more lag, but a clean level
	always_ff @(posedge clk) begin
		if (reset) begin
			irqIdentifier <= `CMH_ID_NONE;
			irq <= 1'b0;
		end else begin
			irqIdentifier <= next_irqIdentifier;
			irq <= (irqIdentifier != `CMH_ID_NONE) & moduleIrqEnable;
		end
	end

	// raw flags for the transmit scheduler in the core
	assign txRequestOut = transmitRequest;

	// -------------------------------------------------
	// object data store
	// -------------------------------------------------
	// all eight bytes are written whatever the length code says
	cmh_obj_s storeObj;
	assign storeObj.dlc = coreEvt.dlc;
	assign storeObj.bytes = coreEvt.bytes;

	// written by the core only; software sees it through the select register
	cmh_obj_store i_cmh_obj_store (
		.clk(clk),
		.writeEn(evtRxData),
		.writeIndex(coreEvt.objIndex),
		.writeObj(storeObj),
		.readIndex(objSelect),
		.readObj(readObj)
	);

	// length code to byte count, 9 and above saturate at eight
	function automatic logic [3:0] dlcBytes(input logic [3:0] code);
		dlcBytes = (code > `CMH_DLC_MAX_BYTES) ? `CMH_DLC_MAX_BYTES : code;
	endfunction

	// -------------------------------------------------
	// read mux
	// -------------------------------------------------
	// status words have no write path at all, so bus writes just fall away
	// control and status words built from the mapped bit positions
	logic [31:0] ctrlWord;
	logic [31:0] statWord;
	always_comb begin
		ctrlWord = 32'h00000000;
		ctrlWord[`CMH_CTRL_IE_BIT] = moduleIrqEnable;
		statWord = 32'h00000000;
		statWord[`CMH_STAT_IRQ_BIT] = statusIrq;
		statWord[`CMH_STAT_RXOK_BIT] = rxOkSeen;
		statWord[`CMH_STAT_TXOK_BIT] = txOkSeen;
	end

	wire [31:0] dataLowWord = {readObj.bytes[3], readObj.bytes[2], readObj.bytes[1], readObj.bytes[0]};
	wire [31:0] dataHighWord = {readObj.bytes[7], readObj.bytes[6], readObj.bytes[5], readObj.bytes[4]};
	wire [31:0] dlcWord = {24'h000000, dlcBytes(readObj.dlc), readObj.dlc};

	// one full word on every branch, so nothing is latched
	always_comb begin
		if (selCtrl) begin
			readWord = ctrlWord;
		end else if (selStat) begin
			readWord = statWord;
		end else if (selId) begin
			readWord = {16'h0000, irqIdentifier};
		end else if (selTxLow) begin
			readWord = {16'h0000, transmitRequest[15:0]};
		end else if (selTxHigh) begin
			readWord = {transmitRequest[31:16], 16'h0000};
		end else if (selPend) begin
			readWord = irqPending;
		end else if (selRxIe) begin
			readWord = rxIrqEnable;
		end else if (selTxIe) begin
			readWord = txIrqEnable;
		end else if (selRmt) begin
			readWord = remoteAnswerEnable;
		end else if (selObj) begin
			readWord = {27'h0000000, objSelect};
		end else if (selDataLow) begin
			readWord = dataLowWord;
		end else if (selDataHigh) begin
			readWord = dataHighWord;
		end else if (selDlc) begin
			readWord = dlcWord;
		end else begin
			readWord = 32'h00000000; // unmapped reads as zero
		end
	end

	// read data is captured on the wait cycle and stands at the accepting edge
	always_ff @(posedge clk) begin
		if (reset) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & ~ackDone) begin
			avs_readdata <= readWord;
		end
	end

endmodule // cmh_status

`default_nettype wire

// ==== cmh_map.svh ====
// register offsets, field positions, reset values for the message handler status block
`ifndef CMH_MAP_SVH
`define CMH_MAP_SVH

`define CMH_ADDR_W 12
`define CMH_OBJ_COUNT 32
`define CMH_CTRL_OFS 12'h000
`define CMH_STAT_OFS 12'h004
`define CMH_IRQ_SOURCE_ID_OFS 12'h010
`define CMH_TX_PENDING_LOW_OFS 12'h100
`define CMH_TX_PENDING_HIGH_OFS 12'h104
`define CMH_IRQ_PENDING_OFS 12'h140
`define CMH_RX_IE_OFS 12'h180
`define CMH_TX_IE_OFS 12'h184
`define CMH_RMT_EN_OFS 12'h188
`define CMH_CMD_OFS 12'h190
`define CMH_OBJ_SEL_OFS 12'h194
`define CMH_DATA_LOW_OFS 12'h198
`define CMH_DATA_HIGH_OFS 12'h19C
`define CMH_DLC_OFS 12'h1A0

`define CMH_CTRL_IE_BIT 1
`define CMH_STAT_TXOK_BIT 3
`define CMH_STAT_RXOK_BIT 4
`define CMH_STAT_IRQ_BIT 7
`define CMH_ID_NONE 16'h0000
`define CMH_ID_STATUS 16'h8000
`define CMH_DLC_MAX_BYTES 4'h8
`define CMH_RESET_WORD 32'h00000000

`endif

// ==== cmh_pkg.sv ====
// types shared by the message handler status block
package cmh_pkg;

	// kind of event reported by the protocol core
	typedef enum logic [1:0] {
		CMH_EVT_RX_DATA,
		CMH_EVT_RX_REMOTE,
		CMH_EVT_TX_DONE,
		CMH_EVT_NONE
	} cmh_evt_e;

	// one completed frame from the protocol core, object index 0 is object 1
	typedef struct packed {
		logic valid;
		cmh_evt_e kind;
		logic [4:0] objIndex;
		logic [3:0] dlc;
		logic [7:0][7:0] bytes; // bytes[0] is the first byte shifted in
	} cmh_core_evt_s;

	// software command opcodes written to the command register
	typedef enum logic [2:0] {
		CMH_CMD_NOP,
		CMH_CMD_SET_TXREQ,
		CMH_CMD_CLR_TXREQ,
		CMH_CMD_SET_PEND,
		CMH_CMD_CLR_PEND
	} cmh_cmd_e;

	// one stored object: length code and eight data bytes
	typedef struct packed {
		logic [3:0] dlc;
		logic [7:0][7:0] bytes;
	} cmh_obj_s;

endpackage

// ==== cmh_obj_store.sv ====
// data store of the 32 message objects, registered read port
`timescale 1ns/1ps
`default_nettype none

module cmh_obj_store
	import cmh_pkg::*;
(
	input wire logic clk,
	input wire logic writeEn,
	input wire logic [4:0] writeIndex,
	input wire cmh_obj_s writeObj,
	input wire logic [4:0] readIndex,
	output cmh_obj_s readObj
);

	cmh_obj_s store [0:31];

	// -------------------------------------------------
	// write and registered read
	// -------------------------------------------------
	// no reset on the array: contents are undefined until a frame lands
	always_ff @(posedge clk) begin
		if (writeEn) begin
			store[writeIndex] <= writeObj;
		end
		readObj <= store[readIndex];
	end

endmodule // cmh_obj_store

`default_nettype wire

// ==== cmh_status_sva.sv ====
// concurrent checks on the ports of the message handler status block
`timescale 1ns/1ps
`default_nettype none
`include "cmh_map.svh"

module cmh_status_sva
	import cmh_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [`CMH_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire cmh_core_evt_s coreEvt,
	input wire logic statusEvent,
	input wire logic [31:0] txRequestOut,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// accepted bus cycles and anything that may move irq
	wire wAcc = avs_write & ~avs_waitrequest;
	wire act = coreEvt.valid | statusEvent | wAcc | (avs_read & ~avs_waitrequest);
	wire evTx = coreEvt.valid & (coreEvt.kind == CMH_EVT_TX_DONE);
	wire rdWait = avs_read & avs_waitrequest;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
		else $error("new request got no wait cycle");
	a_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait cycle");
	a_rd_stable: assert property ($changed(avs_readdata) |-> $past(rdWait))
		else $error("read data moved without a read");

	// ----------------------------------------
	// transmit request flags and irq line
	// ----------------------------------------
	a_txreq_cause: assert property ($changed(txRequestOut) |-> $past(coreEvt.valid) || $past(wAcc))
		else $error("transmit request changed with no cause");
	a_txdone_clear: assert property (evTx && !wAcc |=> !txRequestOut[$past(coreEvt.objIndex)])
		else $error("finished transmission left request set");
	a_remote_only: assert property (coreEvt.valid && coreEvt.kind != CMH_EVT_RX_REMOTE && !wAcc
		|=> (txRequestOut & ~$past(txRequestOut)) == 32'h00000000)
		else $error("request set by a non-remote event");
	a_ro_write: assert property (wAcc && avs_address inside {12'h010, 12'h100, 12'h104} && !coreEvt.valid
		|=> $stable(txRequestOut))
		else $error("write to read-only word had effect");
	a_irq_rise: assert property ($rose(irq) |-> $past(act, 2) || $past(act, 3))
		else $error("irq rose with no cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(act, 2) || $past(act, 3))
		else $error("irq dropped with no cause");

	// main scenarios seen
	c_irq: cover property ($rose(irq));
	c_txdone: cover property (evTx);
	c_remote: cover property (coreEvt.valid && coreEvt.kind == CMH_EVT_RX_REMOTE);
	c_stat_read: cover property (avs_read && !avs_waitrequest && avs_address == 12'h004);
endmodule // cmh_status_sva

bind cmh_status cmh_status_sva i_cmh_status_sva (.clk, .reset, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .coreEvt, .statusEvent,
	.txRequestOut, .irq);

`default_nettype wire

// ==== cmh_core_model.sv ====
// protocol core stand-in: frame events and status events
`timescale 1ns/1ps
`default_nettype none

module cmh_core_model
	import cmh_pkg::*;
(
	input wire logic clk,
	output logic statusEvent,
	output cmh_core_evt_s coreEvt
);
	// quiet at start
	initial begin
		coreEvt = '0;
		coreEvt.kind = CMH_EVT_NONE;
		statusEvent = 1'b0;
	end

	// one-cycle event, bytes[0] first off the wire
	// idle fields carry inverted leftovers
	task automatic send(input cmh_evt_e k, input logic [4:0] i, input logic [3:0] d, input logic [63:0] b);
		@(posedge clk);
		coreEvt <= {1'b1, k, i, d, b};
		@(posedge clk);
		coreEvt <= {1'b0, CMH_EVT_NONE, ~i, ~d, ~b};
		repeat (4) @(posedge clk);
	endtask

	// status interrupt pulse
	task automatic stat();
		@(posedge clk);
		statusEvent <= 1'b1;
		@(posedge clk);
		statusEvent <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule // cmh_core_model

`default_nettype wire

// ==== cmh_status_tb.sv ====
// self-checking bench for the message handler status block
`timescale 1ns/1ps
`default_nettype none

module cmh_status_tb
	import cmh_pkg::*;
;
	logic clk, reset, avs_read, avs_write, avs_waitrequest, irq, statusEvent;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, txRequestOut, v;
	logic [3:0] avs_byteenable;
	cmh_core_evt_s coreEvt;
	int errorCnt, nCompared;
	localparam logic [63:0] B = 64'h8877665544332211;

	cmh_status i_cmh_status (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .coreEvt, .statusEvent, .txRequestOut, .irq);
	cmh_core_model i_cmh_core_model (.clk, .statusEvent, .coreEvt);

	// ----------------------------------------
	// clock, tasks, verdict
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// one bus cycle; request held until waitrequest is seen low, a hang is left to the watchdog
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		nCompared++;
		if (g !== e) begin
			errorCnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		chk(v, e);
	endtask

	task automatic ev(input cmh_evt_e k, input logic [4:0] i, input logic [3:0] d);
		i_cmh_core_model.send(k, i, d, B);
	endtask

	// irq sampled after its two-edge lag has settled
	task automatic irqIs(input logic e);
		repeat (4) @(posedge clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	task automatic print_verdict();
		$display("errors %0d compared %0d", errorCnt, nCompared);
		if (errorCnt == 0 && nCompared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		errorCnt++;
		print_verdict();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 12'h000;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rc(12'h010, 32'h00000000);
		rc(12'h104, 32'h00000000);
		rc(12'h3F0, 32'h00000000);
		wr(12'h000, 32'h00000002);
		wr(12'h180, 32'h00000005);
		ev(CMH_EVT_RX_DATA, 5'h02, 4'hC);
		rc(12'h140, 32'h00000004);
		rc(12'h010, 32'h00000003);
		irqIs(1'b1);
		ev(CMH_EVT_RX_DATA, 5'h01, 4'h2);
		rc(12'h140, 32'h00000004);
		ev(CMH_EVT_RX_DATA, 5'h00, 4'h3);
		rc(12'h010, 32'h00000001);
		i_cmh_core_model.stat();
		rc(12'h010, 32'h00008000);
		bus(1'b0, 12'h004, 32'h00000000);
		chk(v & 32'h00000080, 32'h00000080);
		rc(12'h010, 32'h00000001);
		wr(12'h190, 32'h00000400);
		rc(12'h010, 32'h00000003);
		wr(12'h190, 32'h00000402);
		rc(12'h010, 32'h00000000);
		irqIs(1'b0);
		// stored bytes of object 3, then every length code on object 5
		wr(12'h194, 32'h00000002);
		repeat (2) @(posedge clk);
		rc(12'h198, 32'h44332211);
		rc(12'h19C, 32'h88776655);
		rc(12'h1A0, 32'h0000008C);
		for (int d = 0; d < 16; d++) begin
			logic [3:0] dd;
			dd = d[3:0];
			ev(CMH_EVT_RX_DATA, 5'h04, dd);
			wr(12'h194, 32'h00000004);
			repeat (2) @(posedge clk);
			rc(12'h1A0, {24'h0, (dd > 4'h8) ? 4'h8 : dd, dd});
		end
		// remote answer, software request, finished transmission
		wr(12'h188, 32'h00010000);
		ev(CMH_EVT_RX_REMOTE, 5'h10, 4'h0);
		rc(12'h104, 32'h00010000);
		chk(txRequestOut, 32'h00010000);
		ev(CMH_EVT_RX_REMOTE, 5'h0F, 4'h0);
		rc(12'h100, 32'h00000000);
		wr(12'h190, 32'h00000101);
		rc(12'h100, 32'h00000002);
		wr(12'h184, 32'h00000002);
		ev(CMH_EVT_TX_DONE, 5'h01, 4'h0);
		rc(12'h100, 32'h00000000);
		rc(12'h140, 32'h00000002);
		wr(12'h104, 32'hFFFFFFFF);
		wr(12'h010, 32'h0000FFFF);
		rc(12'h104, 32'h00010000);
		rc(12'h010, 32'h00000002);
		ev(CMH_EVT_TX_DONE, 5'h10, 4'h0);
		rc(12'h140, 32'h00000002);
		rc(12'h104, 32'h00000000);
		// status companions, then the software opcodes not used above
		rc(12'h004, 32'h00000018);
		rc(12'h004, 32'h00000000);
		wr(12'h190, 32'h00000305);
		rc(12'h140, 32'h00000022);
		wr(12'h190, 32'h00000105);
		rc(12'h100, 32'h00000020);
		wr(12'h190, 32'h00000205);
		rc(12'h100, 32'h00000000);
		rc(12'h010, 32'h00000002);
		irqIs(1'b1);
		wr(12'h000, 32'h00000000);
		irqIs(1'b0);
		print_verdict();
	end
endmodule // cmh_status_tb

`default_nettype wire
